/* pkg/srwg_pkg.sv */
// Purpose: Shared constants and carrier types of the supervisor block
// Assumes: 25 MHz system clock
// Notes: Long counts are overridden by top parameters in simulation
`default_nettype none
package srwg_pkg;
	// ****************
	// Timing
	// ****************
	localparam int CLK_KHZ = 25000;
	localparam int T_RESET_MS = 200;
	localparam int T_DEBOUNCE_MS = 10;
	localparam int TMO_W = 23;
	localparam int DB_W = 18;
	localparam logic [TMO_W-1:0] RESET_CYCLES = TMO_W'(T_RESET_MS * CLK_KHZ);
	localparam logic [DB_W-1:0] DEBOUNCE_CYCLES = DB_W'(T_DEBOUNCE_MS * CLK_KHZ);
	// ****************
	// Memory and bus
	// ****************
	localparam int PAGE_BYTES = 16;
	localparam int MEM_BYTES = 256;
	localparam int ADDR_W = 8;
	localparam int SLOT_W = 4;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// Arbitrary target address
	localparam logic [6:0] TARGET_ADDR_DEF = 7'h2A;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] KIND_DEV = 2'h0;
	localparam logic [1:0] KIND_WORD = 2'h1;
	localparam logic [1:0] KIND_DATA = 2'h2;
	// ****************
	// Types
	// ****************
	typedef struct packed {
		logic vld;
		logic [SLOT_W-1:0] base;
		logic [SLOT_W-1:0] slot;
		logic [7:0] data;
	} srwg_slot_t;
	typedef enum logic [2:0] {
		SQ_HOLD = 3'h1,
		SQ_WAIT = 3'h2,
		SQ_RUN = 3'h4
	} srwg_seq_t;
	typedef enum logic [4:0] {
		BS_IDLE = 5'h01,
		BS_RX = 5'h02,
		BS_ACK = 5'h04,
		BS_TX = 5'h08,
		BS_RACK = 5'h10
	} srwg_bus_t;
endpackage
`default_nettype wire

/* logic/srwg_debounce.sv */
// Purpose: Debounce filter for the manual reset input
// Assumes: Input synchronous to clk_sys, idle high
// Notes: Output follows input only after a full stable interval
`timescale 1ns/100ps
`default_nettype none
module srwg_debounce #(
	parameter logic [srwg_pkg::DB_W-1:0] CYCLES = srwg_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Raw and filtered level
	input wire logic raw_in,
	output logic clean_out
);
	typedef struct packed {
		logic clean;
		logic last;
		logic [srwg_pkg::DB_W-1:0] cnt;
	} srwg_db_state_t;
	srwg_db_state_t st_reg;
	srwg_db_state_t st_next;

	assign clean_out = st_reg.clean;

	always_comb begin
		st_next = st_reg;
		st_next.last = raw_in;
		// Any edge restarts the interval, so bounce never leaks through
		if (raw_in != st_reg.last || raw_in == st_reg.clean) begin
			st_next.cnt = '0;
		end else if (st_reg.cnt >= CYCLES - srwg_pkg::DB_W'(1)) begin
			st_next.clean = raw_in;
			st_next.cnt = '0;
		end else begin
			st_next.cnt = st_reg.cnt + srwg_pkg::DB_W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.clean <= 1'b1;
			st_reg.last <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule
`default_nettype wire

/* logic/srwg_store.sv */
// Purpose: Page buffer and byte array behind the serial target
// Assumes: All slot writes of one transaction fall in one page
// Notes: Array returns to erased on reset; retention is not modelled
`timescale 1ns/100ps
`default_nettype none
module srwg_store (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Page fill and commit
	input wire srwg_pkg::srwg_slot_t slot_wr,
	input wire logic page_clr,
	input wire logic commit,
	// Read port and status
	input wire logic [srwg_pkg::ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	output logic busy
);
	typedef struct packed {
		logic busy;
		logic [srwg_pkg::SLOT_W-1:0] idx;
		logic [srwg_pkg::SLOT_W-1:0] base;
		logic [srwg_pkg::PAGE_BYTES-1:0] mask;
	} srwg_store_state_t;
	srwg_store_state_t st_reg;
	srwg_store_state_t st_next;
	logic [7:0] page_reg [srwg_pkg::PAGE_BYTES];
	logic [7:0] mem_reg [srwg_pkg::MEM_BYTES];
	logic [srwg_pkg::ADDR_W-1:0] wr_addr;

	assign wr_addr = {st_reg.base, st_reg.idx};
	assign rd_data = mem_reg[rd_addr];
	assign busy = st_reg.busy;

	always_comb begin
		st_next = st_reg;
		if (st_reg.busy) begin
			st_next.idx = st_reg.idx + 4'h1;
			if (st_reg.idx == 4'hF) begin
				st_next.busy = 1'b0;
				st_next.mask = '0;
			end
		end else if (commit && st_reg.mask != '0) begin
			st_next.busy = 1'b1;
			st_next.idx = '0;
		end else if (page_clr) begin
			st_next.mask = '0;
		end else if (slot_wr.vld) begin
			st_next.mask[slot_wr.slot] = 1'b1;
			st_next.base = slot_wr.base;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Page slots are only read where the mask is set, so no reset
	always_ff @(posedge clk_sys) begin
		if (slot_wr.vld && !st_reg.busy) begin
			page_reg[slot_wr.slot] <= slot_wr.data;
		end
	end

	// ****************
	// Byte array
	// ****************
	for (genvar i = 0; i < srwg_pkg::MEM_BYTES; i++) begin : g_byte
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				mem_reg[i] <= srwg_pkg::ERASED_BYTE;
			end else if (st_reg.busy && st_reg.mask[st_reg.idx] &&
					wr_addr == srwg_pkg::ADDR_W'(i)) begin
				mem_reg[i] <= page_reg[st_reg.idx];
			end
		end
	end
endmodule
`default_nettype wire

/* logic/srwg_top.sv */
// Purpose: Supply supervisor with reset sequencing and write guarding
// Assumes: All pins synchronous to clk_sys; supply_low from a comparator
// Notes: Open-drain pins are split into input, level and enable
//
// How it works
// - Low supply asserts both reset outputs
// - Reset holds a 200 ms timeout after supply
// - Manual reset low holds reset, then timeout
// - Manual reset input is debounced first
// - Outside pull on reset pin starts reset
// - Write protect high rejects every array write
// - Low supply or power-up inhibits all writes
// - Sixteen byte page buffer per write
// - Memory reached only over serial target
// - Data line driven low only, else released
// - Reduced variant drops high reset and protect
`timescale 1ns/100ps
`default_nettype none
module srwg_top #(
	parameter logic FULL_VARIANT = 1'b1,
	parameter logic [6:0] TARGET_ADDR = srwg_pkg::TARGET_ADDR_DEF,
	parameter logic [srwg_pkg::TMO_W-1:0] RESET_CYCLES = srwg_pkg::RESET_CYCLES,
	parameter logic [srwg_pkg::DB_W-1:0] DEBOUNCE_CYCLES = srwg_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Supply sense, reset sources and write protect
	input wire logic supply_low,
	input wire logic manual_reset_n,
	input wire logic wp_in,
	// Active-low reset pin, open drain
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	// Active-high reset output
	output logic rst_hi_out,
	// Serial target pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Status
	output logic wr_inhibit,
	output logic wr_reject,
	output logic [2:0] rst_cause
);
	typedef struct packed {
		srwg_pkg::srwg_seq_t seq;
		logic [srwg_pkg::TMO_W-1:0] tmo;
		logic rst_oe;
		logic rst_hi;
		logic inhibit;
		logic reject;
		logic [2:0] cause;
		srwg_pkg::srwg_bus_t bus;
		logic [1:0] kind;
		logic [3:0] bits;
		logic [7:0] shreg;
		logic rw;
		logic mack;
		logic [srwg_pkg::ADDR_W-1:0] addr;
		logic sda_oe;
		logic scl_d;
		logic sda_d;
		logic wrote;
		logic commit;
		logic clr;
		srwg_pkg::srwg_slot_t slot;
	} srwg_top_state_t;
	srwg_top_state_t st_reg;
	srwg_top_state_t st_next;

	logic mr_clean;
	logic [7:0] rd_data;
	logic busy;
	logic ext_pull;
	logic [2:0] src;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic matched;
	logic wp_eff;

	// ****************
	// Submodules
	// ****************
	srwg_debounce #(
		.CYCLES(DEBOUNCE_CYCLES)
	) u_debounce (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.raw_in(manual_reset_n),
		.clean_out(mr_clean)
	);

	srwg_store u_store (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.slot_wr(st_reg.slot),
		.page_clr(st_reg.clr),
		.commit(st_reg.commit),
		.rd_addr(st_reg.addr),
		.rd_data(rd_data),
		.busy(busy)
	);

	// ****************
	// Outputs
	// ****************
	// Both open-drain pins only ever pull low
	assign rst_pin_out = 1'b0;
	assign sda_out = 1'b0;
	assign rst_pin_oe = st_reg.rst_oe;
	assign rst_hi_out = st_reg.rst_hi;
	assign sda_oe = st_reg.sda_oe;
	assign wr_inhibit = st_reg.inhibit;
	assign wr_reject = st_reg.reject;
	assign rst_cause = st_reg.cause;

	// ****************
	// Source decode
	// ****************
	// While we drive the pin we cannot see an outside pull on it
	assign ext_pull = !rst_pin_in && !st_reg.rst_oe;
	assign src = {ext_pull, !mr_clean, supply_low};
	assign wp_eff = FULL_VARIANT && wp_in;
	assign scl_rise = scl_in && !st_reg.scl_d;
	assign scl_fall = !scl_in && st_reg.scl_d;
	assign bus_start = scl_in && st_reg.scl_d && st_reg.sda_d && !sda_in;
	assign bus_stop = scl_in && st_reg.scl_d && !st_reg.sda_d && sda_in;
	assign matched = st_reg.shreg[7:1] == TARGET_ADDR && !busy;

	always_comb begin
		st_next = st_reg;
		st_next.scl_d = scl_in;
		st_next.sda_d = sda_in;
		st_next.commit = 1'b0;
		st_next.clr = 1'b0;
		st_next.reject = 1'b0;
		st_next.slot.vld = 1'b0;

		// ****************
		// Reset sequencer
		// ****************
		unique case (st_reg.seq)
			srwg_pkg::SQ_HOLD: begin
				st_next.tmo = '0;
				if (src == 3'h0) begin
					st_next.seq = srwg_pkg::SQ_WAIT;
				end
			end
			srwg_pkg::SQ_WAIT: begin
				if (src != 3'h0) begin
					st_next.seq = srwg_pkg::SQ_HOLD;
					st_next.tmo = '0;
				end else if (st_reg.tmo >= RESET_CYCLES - srwg_pkg::TMO_W'(1)) begin
					st_next.seq = srwg_pkg::SQ_RUN;
				end else begin
					st_next.tmo = st_reg.tmo + srwg_pkg::TMO_W'(1);
				end
			end
			srwg_pkg::SQ_RUN: begin
				if (src != 3'h0) begin
					st_next.seq = srwg_pkg::SQ_HOLD;
					st_next.tmo = '0;
				end
			end
		endcase
		if (src != 3'h0) begin
			st_next.cause = src;
		end
		st_next.rst_oe = st_next.seq != srwg_pkg::SQ_RUN;
		st_next.rst_hi = FULL_VARIANT && st_next.seq != srwg_pkg::SQ_RUN;

		// ****************
		// Write guard
		// ****************
		st_next.inhibit = supply_low || wp_eff;

		// ****************
		// Serial target
		// ****************
		if (bus_start) begin
			st_next.bus = srwg_pkg::BS_RX;
			st_next.kind = srwg_pkg::KIND_DEV;
			st_next.bits = 4'h0;
			st_next.sda_oe = 1'b0;
			st_next.wrote = 1'b0;
		end else if (bus_stop) begin
			st_next.bus = srwg_pkg::BS_IDLE;
			st_next.sda_oe = 1'b0;
			st_next.wrote = 1'b0;
			if (st_reg.wrote) begin
				if (st_reg.inhibit) begin
					st_next.reject = 1'b1;
				end else begin
					st_next.commit = 1'b1;
				end
			end
		end else begin
			unique case (st_reg.bus)
				srwg_pkg::BS_IDLE: begin
					st_next.sda_oe = 1'b0;
				end
				srwg_pkg::BS_RX: begin
					if (scl_rise) begin
						st_next.shreg = {st_reg.shreg[6:0], sda_in};
						st_next.bits = st_reg.bits + 4'h1;
					end else if (scl_fall && st_reg.bits == srwg_pkg::BITS_PER_BYTE) begin
						st_next.bits = 4'h0;
						st_next.bus = srwg_pkg::BS_ACK;
						st_next.sda_oe = 1'b1;
						if (st_reg.kind == srwg_pkg::KIND_DEV) begin
							st_next.rw = st_reg.shreg[0];
							st_next.clr = matched && !st_reg.shreg[0];
							if (!matched) begin
								st_next.bus = srwg_pkg::BS_IDLE;
								st_next.sda_oe = 1'b0;
							end
						end else if (st_reg.kind == srwg_pkg::KIND_WORD) begin
							st_next.addr = st_reg.shreg;
						end else begin
							// Address wraps inside the page, as a page buffer must
							st_next.slot.vld = 1'b1;
							st_next.slot.base = st_reg.addr[7:4];
							st_next.slot.slot = st_reg.addr[3:0];
							st_next.slot.data = st_reg.shreg;
							st_next.addr[3:0] = st_reg.addr[3:0] + 4'h1;
							st_next.wrote = 1'b1;
						end
					end
				end
				srwg_pkg::BS_ACK: begin
					if (scl_fall) begin
						st_next.sda_oe = 1'b0;
						if (st_reg.kind == srwg_pkg::KIND_DEV && st_reg.rw) begin
							st_next.bus = srwg_pkg::BS_TX;
							st_next.shreg = rd_data;
							st_next.sda_oe = !rd_data[7];
							st_next.bits = 4'h0;
						end else begin
							st_next.bus = srwg_pkg::BS_RX;
							if (st_reg.kind == srwg_pkg::KIND_DEV) begin
								st_next.kind = srwg_pkg::KIND_WORD;
							end else begin
								st_next.kind = srwg_pkg::KIND_DATA;
							end
						end
					end
				end
				srwg_pkg::BS_TX: begin
					if (scl_fall) begin
						st_next.bits = st_reg.bits + 4'h1;
						if (st_reg.bits == 4'h7) begin
							st_next.bus = srwg_pkg::BS_RACK;
							st_next.sda_oe = 1'b0;
							st_next.addr = st_reg.addr + srwg_pkg::ADDR_W'(1);
						end else begin
							st_next.shreg = {st_reg.shreg[6:0], 1'b0};
							st_next.sda_oe = !st_reg.shreg[6];
						end
					end
				end
				srwg_pkg::BS_RACK: begin
					if (scl_rise) begin
						st_next.mack = !sda_in;
					end else if (scl_fall) begin
						if (st_reg.mack) begin
							st_next.bus = srwg_pkg::BS_TX;
							st_next.shreg = rd_data;
							st_next.sda_oe = !rd_data[7];
							st_next.bits = 4'h0;
						end else begin
							st_next.bus = srwg_pkg::BS_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ****************
	// State register
	// ****************
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.seq <= srwg_pkg::SQ_HOLD;
			st_reg.rst_oe <= 1'b1;
			st_reg.rst_hi <= FULL_VARIANT;
			st_reg.inhibit <= 1'b1;
			st_reg.bus <= srwg_pkg::BS_IDLE;
			st_reg.scl_d <= 1'b1;
			st_reg.sda_d <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule
`default_nettype wire

/* test/srwg_checker.sv */
// Purpose: Port-level checks of the supervisor block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Release bounds come from the top parameters
`timescale 1ns/100ps
`default_nettype none
module srwg_checker #(
	parameter logic FULL_VARIANT = 1'b1,
	parameter logic [srwg_pkg::TMO_W-1:0] RESET_CYCLES = srwg_pkg::RESET_CYCLES,
	parameter logic [srwg_pkg::DB_W-1:0] DEBOUNCE_CYCLES = srwg_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Sources
	input wire logic supply_low,
	input wire logic manual_reset_n,
	input wire logic wp_in,
	input wire logic rst_pin_in,
	input wire logic scl_in,
	input wire logic sda_in,
	// Outputs
	input wire logic rst_pin_out,
	input wire logic rst_pin_oe,
	input wire logic rst_hi_out,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic wr_inhibit,
	input wire logic wr_reject,
	input wire logic [2:0] rst_cause
);
	// ****************
	// Quiet time since the last raw source
	// ****************
	// Raw manual level is used, so the bound allows for the filter delay
	logic [31:0] quiet_reg;
	logic [31:0] lim;
	assign lim = 32'(RESET_CYCLES) + 32'(DEBOUNCE_CYCLES) + 32'h8;
	always_ff @(posedge clk_sys) begin
		if (!rst_n || supply_low || !manual_reset_n || (!rst_pin_in && !rst_pin_oe)) begin
			quiet_reg <= 32'h0;
		end else if (quiet_reg != 32'hFFFFFFFF) begin
			quiet_reg <= quiet_reg + 32'h1;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ****************
	// Assertions
	// ****************
	chk_supply_asserts: assert property (supply_low |-> ##2 (rst_pin_oe && rst_hi_out == FULL_VARIANT))
		else $error("reset not asserted on low supply");
	chk_high_pairs: assert property (rst_hi_out == (FULL_VARIANT & rst_pin_oe))
		else $error("high reset does not mirror low reset");
	chk_timeout_hold: assert property ($fell(rst_pin_oe) |-> quiet_reg >= 32'(RESET_CYCLES))
		else $error("reset released before timeout");
	chk_release_bound: assert property (quiet_reg == lim |-> !rst_pin_oe)
		else $error("reset held too long");
	chk_ext_pull: assert property ((!rst_pin_in && !rst_pin_oe) |-> ##2 rst_pin_oe)
		else $error("outside pull ignored");
	chk_low_inhibit: assert property (supply_low |=> wr_inhibit)
		else $error("write not inhibited on low supply");
	chk_protect_gate: assert property ((FULL_VARIANT && wp_in) |=> wr_inhibit)
		else $error("write not inhibited by protect");
	chk_write_allowed: assert property ($past(rst_n) && !supply_low && !wp_in |=> !wr_inhibit)
		else $error("write inhibited without cause");
	chk_reject_pulse: assert property (wr_reject |=> !wr_reject)
		else $error("reject wider than one cycle");
	chk_reject_cause: assert property (wr_reject |-> $past(wr_inhibit) && scl_in)
		else $error("reject without inhibit");
	chk_open_drain: assert property (sda_out == 1'b0 && rst_pin_out == 1'b0)
		else $error("open-drain level not low");
	chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line moved while clock high");
	chk_cause_supply: assert property (supply_low |=> rst_cause[0])
		else $error("supply cause not recorded");
	cover property ($fell(rst_pin_oe));
	cover property (wr_reject);
	cover property (!rst_pin_in && !rst_pin_oe);
endmodule
`default_nettype wire

/* test/srwg_host.sv */
// Purpose: Host controller on the serial bus and reset wire
// Assumes: Both wires have pull-ups
// Notes: Each bus phase lasts four system clocks
`timescale 1ns/100ps
`default_nettype none
module srwg_host (
	// Clock
	input wire logic clk_sys,
	// Device drive
	input wire logic rst_pin_oe,
	input wire logic sda_oe,
	// Resolved wires
	output logic rst_pin_in,
	output logic scl_in,
	output logic sda_in
);
	logic pull_req = 1'b0;
	logic scl_drv = 1'b1;
	logic sda_drv = 1'b1;
	// Wired-AND with pull-up
	assign rst_pin_in = !(rst_pin_oe | pull_req);
	assign sda_in = sda_drv & !sda_oe;
	assign scl_in = scl_drv;
	task automatic step(input logic c, input logic d);
		scl_drv = c;
		sda_drv = d;
		repeat (4) @(negedge clk_sys);
	endtask
	// Data changes only while the clock is low, MSB first
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			step(1'b0, b[i]);
			step(1'b1, b[i]);
		end
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		ack = !sda_in;
	endtask
	task automatic write3(input logic [7:0] a, input logic [7:0] w, input logic [7:0] d,
		output logic ack);
		logic k1;
		logic k2;
		logic k3;
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		send(a, k1);
		send(w, k2);
		send(d, k3);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		ack = k1 & k2 & k3;
	endtask
	// Random read: word address, repeated start, one byte, master NACK, stop
	task automatic read1(input logic [7:0] a, input logic [7:0] w, output logic [7:0] d,
		output logic ack);
		logic k1;
		logic k2;
		logic k3;
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		send(a, k1);
		send(w, k2);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		send(a | 8'h01, k3);
		for (int i = 7; i >= 0; i--) begin
			step(1'b0, 1'b1);
			step(1'b1, 1'b1);
			d[i] = sda_in;
		end
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		ack = k1 & k2 & k3;
	endtask
endmodule
`default_nettype wire

/* test/supervisor_reset_write_guard_bench.sv */
// Purpose: Self-checking bench of the supervisor block
// Assumes: Short timeout and debounce counts
// Notes: Release and reject events are matched against queued notes
`timescale 1ns/100ps
`default_nettype none
module supervisor_reset_write_guard_bench;
	localparam logic [srwg_pkg::TMO_W-1:0] RC = 23'h000032;
	localparam logic [srwg_pkg::DB_W-1:0] DC = 18'h00008;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic supply_low = 1'b1;
	logic manual_reset_n = 1'b1;
	logic wp_in = 1'b0;
	logic rst_pin_in, rst_pin_out, rst_pin_oe, rst_hi_out, ack;
	logic scl_in, sda_in, sda_out, sda_oe, wr_inhibit, wr_reject;
	logic [2:0] rst_cause;
	logic [7:0] rd;
	logic red_pin_in, red_oe, red_hi, red_inhibit;
	logic [3:0] notes[$];
	logic oe_prev = 1'b1;
	logic [31:0] seed = 32'h0001658B;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #20 clk_sys = ~clk_sys;
	srwg_top #(.RESET_CYCLES(RC), .DEBOUNCE_CYCLES(DC)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
		.supply_low(supply_low), .manual_reset_n(manual_reset_n), .wp_in(wp_in),
		.rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
		.rst_hi_out(rst_hi_out), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .wr_inhibit(wr_inhibit), .wr_reject(wr_reject), .rst_cause(rst_cause));
	srwg_host host (.clk_sys(clk_sys), .rst_pin_oe(rst_pin_oe), .sda_oe(sda_oe),
		.rst_pin_in(rst_pin_in), .scl_in(scl_in), .sda_in(sda_in));
	// Reduced variant on the same inputs except its own reset wire; its data line stays off the wire
	assign red_pin_in = !red_oe;
	srwg_top #(.FULL_VARIANT(1'b0), .RESET_CYCLES(RC), .DEBOUNCE_CYCLES(DC)) DUT_reduced (
		.clk_sys(clk_sys), .rst_n(rst_n), .supply_low(supply_low),
		.manual_reset_n(manual_reset_n), .wp_in(wp_in), .rst_pin_in(red_pin_in),
		.rst_pin_out(), .rst_pin_oe(red_oe), .rst_hi_out(red_hi), .scl_in(scl_in),
		.sda_in(sda_in), .sda_out(), .sda_oe(), .wr_inhibit(red_inhibit), .wr_reject(),
		.rst_cause());
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic check(input logic [3:0] got, input logic [3:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	function automatic logic [3:0] take();
		if (notes.size() == 0) begin
			return 4'hF;
		end
		return notes.pop_front();
	endfunction
	task automatic wait_rel();
		while (rst_pin_oe !== 1'b0) @(negedge clk_sys);
		repeat (4) @(negedge clk_sys);
	endtask
	// ****************
	// Watcher: one note per release or reject
	// ****************
	// Falling edge, so registered outputs are settled when looked at
	always @(negedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			$display("[FAIL] %0t run too long", $time);
			give_verdict();
		end
		if (rst_n && oe_prev === 1'b1 && rst_pin_oe === 1'b0) begin
			check({1'b0, rst_cause}, take(), "wrong release cause");
		end
		if (rst_n && wr_reject === 1'b1) begin
			check(4'h8, take(), "unexpected reject");
		end
		oe_prev <= rst_pin_oe;
	end
	// ****************
	// Stimulus
	// ****************
	initial begin
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		check({2'h0, rst_pin_oe, rst_hi_out}, 4'h3, "reset not asserted at start");
		check({3'h0, wr_inhibit}, 4'h1, "write open at power-up");
		check({2'h0, red_oe, red_hi}, 4'h2, "reduced variant high reset driven");
		repeat (20) @(negedge clk_sys);
		notes.push_back(4'h1);
		supply_low = 1'b0;
		wait_rel();
		// A glitch shorter than the filter must not reach the reset pin
		manual_reset_n = 1'b0;
		repeat (3) @(negedge clk_sys);
		manual_reset_n = 1'b1;
		repeat (12) @(negedge clk_sys);
		check({3'h0, rst_pin_oe}, 4'h0, "short glitch caused reset");
		// Random bounce, then a firm press
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			manual_reset_n = seed[0];
			@(negedge clk_sys);
		end
		manual_reset_n = 1'b0;
		notes.push_back(4'h2);
		repeat (20) @(negedge clk_sys);
		manual_reset_n = 1'b1;
		wait_rel();
		notes.push_back(4'h4);
		host.pull_req = 1'b1;
		repeat (5) @(negedge clk_sys);
		host.pull_req = 1'b0;
		wait_rel();
		// A second dip in mid-timeout must restart the count
		notes.push_back(4'h1);
		supply_low = 1'b1;
		repeat (3) @(negedge clk_sys);
		supply_low = 1'b0;
		repeat (30) @(negedge clk_sys);
		supply_low = 1'b1;
		repeat (3) @(negedge clk_sys);
		supply_low = 1'b0;
		wait_rel();
		seed = xs(seed);
		wp_in = 1'b1;
		notes.push_back(4'h8);
		host.write3({srwg_pkg::TARGET_ADDR_DEF, 1'b0}, seed[7:0], seed[15:8], ack);
		check({3'h0, ack}, 4'h1, "protected write not acked");
		check({3'h0, wr_inhibit}, 4'h1, "protect not inhibiting");
		check({3'h0, red_inhibit}, 4'h0, "reduced variant honours protect");
		host.read1({srwg_pkg::TARGET_ADDR_DEF, 1'b0}, seed[7:0], rd, ack);
		check({3'h0, ack}, 4'h1, "protected read not acked");
		check({3'h0, rd === srwg_pkg::ERASED_BYTE}, 4'h1, "protected write landed");
		repeat (20) @(negedge clk_sys);
		wp_in = 1'b0;
		repeat (4) @(negedge clk_sys);
		host.write3({srwg_pkg::TARGET_ADDR_DEF, 1'b0}, seed[23:16], seed[31:24], ack);
		check({3'h0, ack}, 4'h1, "open write not acked");
		repeat (30) @(negedge clk_sys);
		host.read1({srwg_pkg::TARGET_ADDR_DEF, 1'b0}, seed[23:16], rd, ack);
		check({3'h0, ack}, 4'h1, "open read not acked");
		check({3'h0, rd === seed[31:24]}, 4'h1, "open write lost");
		check(4'(notes.size()), 4'h0, "expected event missing");
		give_verdict();
	end
endmodule
bind srwg_top srwg_checker #(.FULL_VARIANT(FULL_VARIANT), .RESET_CYCLES(RESET_CYCLES),
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.supply_low(supply_low), .manual_reset_n(manual_reset_n), .wp_in(wp_in),
	.rst_pin_in(rst_pin_in), .scl_in(scl_in), .sda_in(sda_in), .rst_pin_out(rst_pin_out),
	.rst_pin_oe(rst_pin_oe), .rst_hi_out(rst_hi_out), .sda_out(sda_out), .sda_oe(sda_oe),
	.wr_inhibit(wr_inhibit), .wr_reject(wr_reject), .rst_cause(rst_cause));
`default_nettype wire
